//--- include/vgagr_cfg.svh
// Offsets, field positions and reset values of the general register bank.
// Assumes inclusion by bare name from the include/ folder.
`ifndef VGAGR_CFG_SVH
`define VGAGR_CFG_SVH

// ----------------------------------------------------------------
// Port addresses
// ----------------------------------------------------------------
`define VGAGR_MISC_RD_PORT   16'h03cc
`define VGAGR_MISC_WR_PORT   16'h03c2
`define VGAGR_STAT0_PORT     16'h03c2
`define VGAGR_VSE_PORT       16'h03c3
`define VGAGR_FEAT_RD_PORT   16'h03ca
`define VGAGR_MONO_STAT_PORT 16'h03ba
`define VGAGR_COLR_STAT_PORT 16'h03da
`define VGAGR_MONO_IDX_PORT  16'h03b4
`define VGAGR_COLR_IDX_PORT  16'h03d4
`define VGAGR_MONO_DAT_PORT  16'h03b5
`define VGAGR_COLR_DAT_PORT  16'h03d5
`define VGAGR_VSE_ALT_PORT   16'h46e8
`define VGAGR_SETUP_PORT     16'h0102

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VGAGR_MISC_VPOL      7
`define VGAGR_MISC_HPOL      6
`define VGAGR_MISC_PAGE      5
`define VGAGR_MISC_CLK_HI    3
`define VGAGR_MISC_CLK_LO    2
`define VGAGR_MISC_RAM_EN    1
`define VGAGR_MISC_COLOR     0
`define VGAGR_STAT0_IRQ      7
`define VGAGR_STAT0_MON      4
`define VGAGR_STAT1_VRTR     3
`define VGAGR_STAT1_BLANK    0
`define VGAGR_FEAT_VSOR      3
`define VGAGR_VSE_BIT        0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define VGAGR_MISC_RST       8'h00
`define VGAGR_FEAT_RST       8'h00
`define VGAGR_VSE_RST        8'h00

`endif

//--- include/vgagr_pkg.sv
// Types shared by the general register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package vgagr_pkg;

    // Host bus access phase
    typedef enum logic [2:0] {
        VGAGR_IDLE  = 3'b001,
        VGAGR_WRITE = 3'b010,
        VGAGR_READ  = 3'b100
    } vgagr_phase_t;

endpackage

//--- hdl/vgagr_regs.sv
// General register bank of the display controller on the host I/O bus.
// Assumes timing status from display timing logic on the same clock and
// the monitor sense pin arriving asynchronously.
//
// How it works
// [R01] Misc output written 3C2h, read 3CCh
// [R02] Misc bit 7 picks vertical sync polarity
// [R03] Misc bit 6 picks horizontal sync polarity
// [R04] Software encodes vertical size; 00 unused
// [R05] Misc bit 5 picks upper/lower page
// [R06] Misc 3:2 with extension choose clock
// [R07] Misc bit 1 gates host memory access
// [R08] Misc bit 0 moves timing ports, status
// [R09] Status 0 bit 7 shows pending interrupt
// [R10] Status 0 bit 4 reports monitor presence
// [R11] Status 1 5:4 muxed pixel bits
// [R12] Status 1 bit 3 shows vertical retrace
// [R13] Status 1 bit 0 shows blanking
// [R14] Feature bit 3 ORs vsync with display enable
// [R15] Port 3C3h may replace setup ports
// [R16] Question-mark ports follow addressing range
// [R17] Status writes change no status bits
//
// The strap settles a few edges after reset; until then port 3C3h may
// stand in for the setup ports when AT mode is set.
// Status bits are never stored, so host writes cannot disturb them.
`timescale 1ns/1ps
`include "vgagr_cfg.svh"

module vgagr_regs
    import vgagr_pkg::*;
(
    input  wire logic        CLOCK_I,        // 20 MHz bus clock
    input  wire logic        RSTN_I,         // Sync reset, active low
    input  wire logic [15:0] IO_ADDR_I,      // I/O port address
    input  wire logic        IO_WR_I,        // Write strobe, one cycle
    input  wire logic        IO_RD_I,        // Read strobe, one cycle
    input  wire logic [7:0]  IO_WDATA_I,     // Write data
    output logic      [7:0]  IO_RDATA_O,     // Read data, registered
    output logic             IO_HIT_O,       // Read answered, one cycle
    input  wire logic        AT_MODE_I,      // AT bus mode
    input  wire logic        PORT_REPLACE_STRAP_I, // Strap level
    input  wire logic        EXT_DAC_MODE_I, // External palette DAC mode
    input  wire logic        MONITOR_SENSE_INPUT_I, // Async sense pin
    input  wire logic        MON_PRESENT_I,  // Internal monitor status
    input  wire logic        VRTR_IRQ_I,     // Retrace interrupt pending
    input  wire logic        VRETRACE_I,     // Vertical retrace active
    input  wire logic        DISP_EN_I,      // Active display area
    input  wire logic        VDISP_EN_I,     // Vertical display enable
    input  wire logic        VSYNC_I,        // Raw vertical sync
    input  wire logic        HSYNC_I,        // Raw horizontal sync
    input  wire logic [7:0]  PIXEL_I,        // Pixel bits zero..seven
    input  wire logic [5:4]  PLANE_EN_I,     // Colour plane enable 5:4
    input  wire logic [1:0]  CLOCK_SELECT_EXTENSION_I, // Clock ext field
    output logic             VSYNC_O,        // Vertical sync pin
    output logic             HSYNC_O,        // Horizontal sync pin
    output logic             PAGE_HI_O,      // Upper 64KB page
    output logic [3:0]       CLK_SEL_O,      // Video clock choice
    output logic             RAM_EN_O,       // Host memory access allowed
    output logic             COLOR_MAP_O,    // Colour range decode
    output logic             DISPLAY_TIMING_CONTROLLER_IDX_HIT_O, // Timing index port hit
    output logic             DISPLAY_TIMING_CONTROLLER_DAT_HIT_O, // Timing data port hit
    output logic             SETUP_HIT_O,    // Setup port decode hit
    output logic             VSE_ENABLE_O    // Video subsystem enable
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]  misc_ff;
    logic [7:0]  feat_ff;
    logic [7:0]  vse_ff;
    logic [7:0]  rdata_ff;
    logic        hit_ff;
    logic        strap_ff;
    logic [2:0]  strap_sync_ff;
    logic [2:0]  sense_ff;
    logic        sense_ff_q;
    logic        vs_ff;
    logic        hs_ff;
    vgagr_phase_t phase;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire        color   = misc_ff[`VGAGR_MISC_COLOR];
    wire [15:0] stat1_a = color ? `VGAGR_COLR_STAT_PORT
                                : `VGAGR_MONO_STAT_PORT; // see [R16]
    wire        sel_misc_wr = IO_ADDR_I == `VGAGR_MISC_WR_PORT; // see [R01]
    wire        sel_misc_rd = IO_ADDR_I == `VGAGR_MISC_RD_PORT; // see [R01]
    wire        sel_stat0   = IO_ADDR_I == `VGAGR_STAT0_PORT;   // see [R09]
    wire        sel_vse     = IO_ADDR_I == `VGAGR_VSE_PORT;
    wire        sel_feat_rd = IO_ADDR_I == `VGAGR_FEAT_RD_PORT;
    wire        sel_qa      = IO_ADDR_I == stat1_a;             // see [R08]
    wire        replace_on  = AT_MODE_I && !strap_ff
                              && !vse_ff[`VGAGR_VSE_BIT];       // see [R15]
    wire        setup_port  = IO_ADDR_I == `VGAGR_VSE_ALT_PORT
                              || IO_ADDR_I == `VGAGR_SETUP_PORT;

    assign phase = IO_WR_I ? VGAGR_WRITE
                 : IO_RD_I ? VGAGR_READ : VGAGR_IDLE;

    // Timing controller ports follow the range bit
    assign DISPLAY_TIMING_CONTROLLER_IDX_HIT_O = IO_ADDR_I == (color ? `VGAGR_COLR_IDX_PORT
                          : `VGAGR_MONO_IDX_PORT); // see [R08]
    assign DISPLAY_TIMING_CONTROLLER_DAT_HIT_O = IO_ADDR_I == (color ? `VGAGR_COLR_DAT_PORT
                          : `VGAGR_MONO_DAT_PORT); // see [R16]
    // Setup ports decode only while port 3C3h does not stand in
    assign SETUP_HIT_O = setup_port && !replace_on; // see [R15]

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    function automatic logic [1:0] diag_pick(input logic [1:0] sel,
                                             input logic [7:0] pix);
        case (sel)
            2'b00:   diag_pick = {pix[2], pix[0]};
            2'b01:   diag_pick = {pix[5], pix[4]};
            2'b10:   diag_pick = {pix[3], pix[1]};
            2'b11:   diag_pick = {pix[7], pix[6]};
            default: diag_pick = 2'b00;
        endcase
    endfunction

    wire        mon_bit = EXT_DAC_MODE_I ? sense_ff_q
                                         : MON_PRESENT_I; // see [R10]
    wire [7:0]  stat0 = {VRTR_IRQ_I, 2'b00, mon_bit, 4'h0}; // see [R09]
    wire [7:0]  stat1 = {2'b00, diag_pick(PLANE_EN_I, PIXEL_I), // see [R11]
                         VRETRACE_I, 2'b00, !DISP_EN_I}; // see [R12] [R13]
    wire        vse_rd  = sel_vse && (!AT_MODE_I || replace_on);
    wire        rd_hit  = sel_misc_rd || sel_stat0 || sel_feat_rd
                          || sel_qa || vse_rd;
    wire [7:0]  rd_mux  = sel_misc_rd ? misc_ff
                        : sel_stat0   ? stat0
                        : sel_feat_rd ? feat_ff
                        : sel_qa      ? stat1
                        : vse_rd      ? vse_ff : 8'h00;

    // Read data registered, answer one cycle after strobe
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            rdata_ff <= 8'h00;
            hit_ff   <= 1'b0;
        end else begin
            hit_ff   <= (phase == VGAGR_READ) && rd_hit;
            rdata_ff <= (phase == VGAGR_READ) ? rd_mux : 8'h00;
        end
    end
    assign IO_RDATA_O = rdata_ff;
    assign IO_HIT_O   = hit_ff;

    // ----------------------------------------------------------------
    // Register writes; status is not stored so writes cannot alter it
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            misc_ff <= `VGAGR_MISC_RST;
            feat_ff <= `VGAGR_FEAT_RST;
            vse_ff  <= `VGAGR_VSE_RST;
        end else if (phase == VGAGR_WRITE) begin
            if (sel_misc_wr)
                misc_ff <= IO_WDATA_I; // see [R01] [R17]
            if (sel_qa)
                feat_ff <= {4'h0, IO_WDATA_I[3], 3'b000}; // see [R14]
            if (sel_vse)
                vse_ff <= {7'h00, IO_WDATA_I[0]}; // see [R15]
        end
    end

    // Strap pin through three flops; level taken once two stages agree
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            strap_sync_ff <= 3'b000;
            strap_ff      <= 1'b0;
        end else begin
            strap_sync_ff <= {strap_sync_ff[1:0], PORT_REPLACE_STRAP_I};
            if (strap_sync_ff[2] == strap_sync_ff[1])
                strap_ff <= strap_sync_ff[1]; // see [R15]
        end
    end

    // Sense pin synchroniser; change accepted when stages 2 and 3 agree
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            sense_ff   <= 3'b000;
            sense_ff_q <= 1'b0;
        end else begin
            sense_ff <= {sense_ff[1:0], MONITOR_SENSE_INPUT_I};
            if (sense_ff[2] == sense_ff[1])
                sense_ff_q <= sense_ff[1]; // see [R10]
        end
    end

    // ----------------------------------------------------------------
    // Sync outputs
    // ----------------------------------------------------------------
    wire vs_src = feat_ff[`VGAGR_FEAT_VSOR] ? (VSYNC_I || VDISP_EN_I)
                                            : VSYNC_I; // see [R14]
    always_ff @(posedge CLOCK_I) begin
        if (!RSTN_I) begin
            vs_ff   <= 1'b0;
            hs_ff   <= 1'b0;
        end else begin
            vs_ff   <= vs_src ^ misc_ff[`VGAGR_MISC_VPOL];  // see [R02]
            hs_ff   <= HSYNC_I ^ misc_ff[`VGAGR_MISC_HPOL]; // see [R03]
        end
    end
    assign VSYNC_O = vs_ff;
    assign HSYNC_O = hs_ff;

    // Control fields straight from the registers; clock select adds the extension input
    assign PAGE_HI_O    = misc_ff[`VGAGR_MISC_PAGE]; // see [R05]
    assign CLK_SEL_O    = {CLOCK_SELECT_EXTENSION_I,
                           misc_ff[`VGAGR_MISC_CLK_HI:`VGAGR_MISC_CLK_LO]};
                           // see [R06]
    assign RAM_EN_O     = misc_ff[`VGAGR_MISC_RAM_EN]; // see [R07]
    assign COLOR_MAP_O  = color;                      // see [R08]
    assign VSE_ENABLE_O = vse_ff[`VGAGR_VSE_BIT];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    // Host bus answers and register landing
    misc_read_a: assert property ( // see [R01]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_RD_I && !IO_WR_I && sel_misc_rd
        |=> IO_RDATA_O == $past(misc_ff))
        else $error("misc readback mismatch");
    misc_write_a: assert property ( // see [R01]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_WR_I && sel_misc_wr
        |=> misc_ff == $past(IO_WDATA_I))
        else $error("misc write lost");
    idle_data_a: assert property (
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        !IO_RD_I || IO_WR_I
        |=> IO_RDATA_O == 8'h00 && !IO_HIT_O)
        else $error("read data not idle");

    // Sync outputs; reset cycle excluded so a high source cannot trip them
    vsync_pol_a: assert property ( // see [R02]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        $past(RSTN_I)
        |-> VSYNC_O == ($past(vs_src) ^ $past(misc_ff[7])))
        else $error("vsync polarity wrong");
    hsync_pol_a: assert property ( // see [R03]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        $past(RSTN_I)
        |-> HSYNC_O == ($past(HSYNC_I) ^ $past(misc_ff[6])))
        else $error("hsync polarity wrong");
    vsync_or_a: assert property ( // see [R14]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        feat_ff[3] && VDISP_EN_I
        |=> VSYNC_O == !$past(misc_ff[7]))
        else $error("vsync gating wrong");

    // Control fields follow the last misc write; clock extension bits follow their input
    page_sel_a: assert property ( // see [R05]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_WR_I && sel_misc_wr
        |=> PAGE_HI_O == $past(IO_WDATA_I[5]))
        else $error("page select wrong");
    clk_sel_a: assert property ( // see [R06]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_WR_I && sel_misc_wr
        |=> CLK_SEL_O[1:0] == $past(IO_WDATA_I[3:2]))
        else $error("clock select wrong");
    clk_ext_a: assert property ( // see [R06]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        1'b1
        |-> CLK_SEL_O[3:2] == CLOCK_SELECT_EXTENSION_I)
        else $error("clock extension wrong");
    ram_gate_a: assert property ( // see [R07]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_WR_I && sel_misc_wr
        |=> RAM_EN_O == $past(IO_WDATA_I[1]))
        else $error("ram gate wrong");
    color_map_a: assert property ( // see [R08]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_WR_I && sel_misc_wr
        |=> COLOR_MAP_O == $past(IO_WDATA_I[0]))
        else $error("range bit wrong");

    // Port decodes move with the range bit; setup and 3C3h decodes follow AT mode replacement
    display_timing_controller_idx_a: assert property ( // see [R08]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_ADDR_I == (COLOR_MAP_O ? 16'h03d4 : 16'h03b4)
        |-> DISPLAY_TIMING_CONTROLLER_IDX_HIT_O)
        else $error("index decode wrong");
    display_timing_controller_dat_a: assert property ( // see [R16]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_ADDR_I == (COLOR_MAP_O ? 16'h03d5 : 16'h03b5)
        |-> DISPLAY_TIMING_CONTROLLER_DAT_HIT_O)
        else $error("data decode wrong");
    range_sel_a: assert property ( // see [R16]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_ADDR_I == 16'h03da && !COLOR_MAP_O
        |-> !sel_qa)
        else $error("range decode wrong");
    setup_rep_a: assert property ( // see [R15]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        replace_on
        |-> !SETUP_HIT_O)
        else $error("setup ports not replaced");
    vse_gate_a: assert property ( // see [R15]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_RD_I && !IO_WR_I && sel_vse && AT_MODE_I && !replace_on
        |=> !IO_HIT_O)
        else $error("unused enable port answered");

    // Status reads show live inputs, the sense bit after its synchroniser; writes leave them alone
    stat0_irq_a: assert property ( // see [R09]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_RD_I && !IO_WR_I && sel_stat0
        |=> IO_RDATA_O[7] == $past(VRTR_IRQ_I))
        else $error("interrupt bit wrong");
    stat0_mon_a: assert property ( // see [R10]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_RD_I && !IO_WR_I && sel_stat0 && !EXT_DAC_MODE_I
        |=> IO_RDATA_O[4] == $past(MON_PRESENT_I))
        else $error("monitor bit wrong");
    stat0_sense_a: assert property ( // see [R10]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_RD_I && !IO_WR_I && sel_stat0 && EXT_DAC_MODE_I
        |=> IO_RDATA_O[4] == $past(sense_ff_q))
        else $error("sense bit wrong");
    stat1_rtr_a: assert property ( // see [R12]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_RD_I && !IO_WR_I && sel_qa
        |=> IO_RDATA_O[3] == $past(VRETRACE_I))
        else $error("retrace status wrong");
    stat1_blank_a: assert property ( // see [R13]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_RD_I && !IO_WR_I && sel_qa
        |=> IO_RDATA_O[0] == !$past(DISP_EN_I))
        else $error("blank status wrong");
    plane_diag_a: assert property ( // see [R11]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_RD_I && !IO_WR_I && sel_qa && PLANE_EN_I == 2'b11
        |=> IO_RDATA_O[5:4] == $past(PIXEL_I[7:6]))
        else $error("diagnostic bits wrong");
    feat_write_a: assert property ( // see [R14]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_WR_I && sel_qa
        |=> feat_ff[3] == $past(IO_WDATA_I[3]))
        else $error("feature write lost");
    stat_write_a: assert property ( // see [R17]
        @(posedge CLOCK_I) disable iff (!RSTN_I)
        IO_WR_I && (sel_qa || sel_stat0)
        |=> !IO_HIT_O && IO_RDATA_O == 8'h00)
        else $error("status write answered");

endmodule

//--- sim/vgagr_host.sv
// Host processor model issuing single byte I/O cycles.
// Assumes the bank takes a strobe on the rising edge and answers by the
// following falling edge.
`timescale 1ns/1ps

module vgagr_host (
    input  wire logic        clk_i,   // Bus clock
    input  wire logic [7:0]  rdata_i, // Read data
    input  wire logic        hit_i,   // Read answered
    output logic      [15:0] addr_o,  // Port address
    output logic             wr_o,    // Write strobe
    output logic             rd_o,    // Read strobe
    output logic      [7:0]  wdata_o  // Write data
);
    // Idle bus from time zero
    initial begin
        addr_o  = 16'h0000;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 8'h00;
    end

    // One-cycle write strobe launched off the falling edge
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o  = a;
        wdata_o = d;
        wr_o    = 1'b1;
        @(negedge clk_i);
        wr_o    = 1'b0;
        wdata_o = ~d;  // Stale data must not be reused
    endtask

    // One-cycle read strobe; answer stands for one cycle only
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d,
                         output logic h);
        @(negedge clk_i);
        addr_o = a;
        rd_o   = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        d    = rdata_i;
        h    = hit_i;
    endtask
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the general register bank.
// Assumes the host model drives the I/O bus; status inputs come from here.
`timescale 1ns/1ps

module tb_top;
    logic       clk = 1'b0, rstn = 1'b0, at_mode = 1'b0, ext_dac = 1'b0;
    logic       sense = 1'b0, mon = 1'b0, irq = 1'b0, vrtr = 1'b0;
    logic       disp = 1'b0, vdisp = 1'b0, vs = 1'b0, hs = 1'b0;
    logic [7:0] pix = 8'hb4, rd_d, wdata, rdata;
    logic [1:0] plane = 2'b00, ext = 2'b10;
    logic [15:0] addr;
    logic       wr, rd, hit, rd_h, vs_o, hs_o, page, ram, color, vse;
    logic       strap = 1'b0, idx_hit, dat_hit, setup_hit;
    logic [3:0] clk_sel;
    int         failures = 0, n_checks = 0;

    always #25 clk = ~clk;

    vgagr_host host (.clk_i(clk), .rdata_i(rdata), .hit_i(hit),
        .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

    vgagr_regs DUT (.CLOCK_I(clk), .RSTN_I(rstn), .IO_ADDR_I(addr),
        .IO_WR_I(wr), .IO_RD_I(rd), .IO_WDATA_I(wdata), .IO_RDATA_O(rdata),
        .IO_HIT_O(hit), .AT_MODE_I(at_mode), .PORT_REPLACE_STRAP_I(strap),
        .EXT_DAC_MODE_I(ext_dac), .MONITOR_SENSE_INPUT_I(sense),
        .MON_PRESENT_I(mon), .VRTR_IRQ_I(irq), .VRETRACE_I(vrtr),
        .DISP_EN_I(disp), .VDISP_EN_I(vdisp), .VSYNC_I(vs), .HSYNC_I(hs),
        .PIXEL_I(pix), .PLANE_EN_I(plane), .CLOCK_SELECT_EXTENSION_I(ext),
        .VSYNC_O(vs_o), .HSYNC_O(hs_o), .PAGE_HI_O(page), .CLK_SEL_O(clk_sel),
        .RAM_EN_O(ram), .COLOR_MAP_O(color), .DISPLAY_TIMING_CONTROLLER_IDX_HIT_O(idx_hit),
        .DISPLAY_TIMING_CONTROLLER_DAT_HIT_O(dat_hit), .SETUP_HIT_O(setup_hit),
        .VSE_ENABLE_O(vse));

    // Compare one value and count it
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Size codes 01, 10, 11 with page, clock, RAM and range fields
    task automatic t_misc;
        logic [7:0] v [3] = '{8'h43, 8'h8d, 8'he2};
        for (int i = 0; i < 3; i++) begin
            host.io_wr(16'h03c2, v[i]);
            chk("wr_no_hit", 8'h00, {7'h00, hit});
            host.io_rd(16'h03cc, rd_d, rd_h);
            chk("misc_rd", v[i], rd_d);
            chk("misc_hit", 8'h01, {7'h00, rd_h});
            chk("vsync_pol", {7'h00, v[i][7]}, {7'h00, vs_o});
            chk("hsync_pol", {7'h00, v[i][6]}, {7'h00, hs_o});
            chk("page", {7'h00, v[i][5]}, {7'h00, page});
            chk("clk", {4'h0, ext, v[i][3:2]}, {4'h0, clk_sel});
            chk("ram_en", {7'h00, v[i][1]}, {7'h00, ram});
            chk("color", {7'h00, v[i][0]}, {7'h00, color});
        end
    endtask

    // Status one moves with the range bit; diagnostics follow plane enable
    task automatic t_stat1;
        logic [1:0] dg;
        logic [7:0] ex;
        host.io_wr(16'h03c2, 8'h01);
        host.io_rd(16'h03ba, rd_d, rd_h);
        chk("stat1_mono_hit", 8'h00, {7'h00, rd_h});
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            plane = k[1:0];
            vrtr  = k[0];
            disp  = k[1];
            case (k)
                0: dg = {pix[2], pix[0]};
                1: dg = {pix[5], pix[4]};
                2: dg = {pix[3], pix[1]};
                default: dg = {pix[7], pix[6]};
            endcase
            ex = {2'b00, dg, k[0], 2'b00, ~k[1]};
            host.io_rd(16'h03da, rd_d, rd_h);
            chk("stat1", ex, rd_d & 8'h39);
        end
        host.io_wr(16'h03c2, 8'h40);
        host.io_rd(16'h03ba, rd_d, rd_h);
        chk("stat1_mono", {4'h0, 1'b1, 3'b000}, rd_d & 8'h09);
    endtask

    // Status zero; a write to its port lands in misc only
    task automatic t_stat0;
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            irq = k[0];
            mon = k[1];
            host.io_wr(16'h03c2, 8'h41);
            host.io_rd(16'h03c2, rd_d, rd_h);
            chk("stat0", {k[0], 2'b00, k[1], 4'h0}, rd_d & 8'h90);
        end
        @(negedge clk);
        ext_dac = 1'b1;
        mon     = 1'b0;
        sense   = 1'b1;
        repeat (4) @(negedge clk);
        host.io_rd(16'h03c2, rd_d, rd_h);
        chk("stat0_sense", 8'h10, rd_d & 8'h10);
        host.io_rd(16'h03cc, rd_d, rd_h);
        chk("misc_after", 8'h41, rd_d);
    endtask

    // Feature write only at the active range; vsync ORed with display
    task automatic t_feat;
        host.io_wr(16'h03c2, 8'h01);
        host.io_wr(16'h03ba, 8'h08);
        host.io_rd(16'h03ca, rd_d, rd_h);
        chk("feat_wrong", 8'h00, rd_d & 8'h08);
        vdisp = 1'b1;
        host.io_wr(16'h03da, 8'h08);
        host.io_rd(16'h03ca, rd_d, rd_h);
        chk("feat", 8'h08, rd_d & 8'h08);
        chk("vsync_or", 8'h01, {7'h00, vs_o});
        host.io_wr(16'h03da, 8'h00);
        @(negedge clk);
        chk("vsync_plain", 8'h00, {7'h00, vs_o});
    endtask

    // Enable port, AT mode replacement, timing decodes, an unmapped port
    task automatic t_vse;
        host.io_wr(16'h03c3, 8'hff);
        host.io_rd(16'h03c3, rd_d, rd_h);
        chk("vse", 8'h01, rd_d);
        chk("vse_out", 8'h01, {7'h00, vse});
        @(negedge clk);
        at_mode = 1'b1;
        host.io_rd(16'h03c3, rd_d, rd_h);
        chk("vse_unused", 8'h00, {7'h00, rd_h});
        host.io_rd(16'h46e8, rd_d, rd_h);
        chk("setup_kept", 8'h01, {7'h00, setup_hit});
        host.io_wr(16'h03c3, 8'h00);
        host.io_rd(16'h03c3, rd_d, rd_h);
        chk("vse_repl", 8'h01, {7'h00, rd_h});
        host.io_rd(16'h0102, rd_d, rd_h);
        chk("setup_repl", 8'h00, {7'h00, setup_hit});
        host.io_rd(16'h03d4, rd_d, rd_h);
        chk("idx_color", 8'h01, {7'h00, idx_hit});
        host.io_rd(16'h03b5, rd_d, rd_h);
        chk("dat_mono", 8'h00, {7'h00, dat_hit});
        host.io_rd(16'h0300, rd_d, rd_h);
        chk("unmapped", 8'h00, rd_d | {7'h00, rd_h});
    endtask

    // Print counts and the verdict, then stop
    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog well past the roughly 115 cycles the tests need
    initial begin
        #200000;
        failures++;
        finish_test();
    end

    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        t_misc();
        t_stat1();
        t_stat0();
        t_feat();
        t_vse();
        finish_test();
    end
endmodule
